// ---- core/dpcm_ext_bus.sv ----
// External code fetch bus sequencer
`timescale 1ns/1ns
module dpcm_ext_bus
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Request
    input wire logic req_in,
    input wire logic [15:0] addr_in,
    output logic busy_out,
    output logic done_out,
    output logic [7:0] data_out,
    // Pins
    input wire logic [7:0] ad_sync_in,
    output logic [7:0] ad_o_out,
    output logic [7:0] ad_oe_n_out,
    output logic [7:0] upper_address_out,
    output logic ale_out,
    output logic program_store_strobe_n_out
);
    import dpcm_pkg::*;
    dpcm_bus_state_t state_ff;
    logic [2:0] cnt_ff;
    logic [15:0] addr_ff;
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_ff <= DPCM_IDLE;
            cnt_ff <= 3'h0;
            addr_ff <= 16'h0000;
        end
        else
        begin
            case (state_ff)
                DPCM_IDLE:
                begin
                    cnt_ff <= 3'h0;
                    if (req_in)
                    begin
                        addr_ff <= addr_in;
                        state_ff <= DPCM_ADDR;
                    end
                end
                DPCM_ADDR:
                begin
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == ALE_END)
                        state_ff <= DPCM_DATA;
                end
                DPCM_DATA:
                begin
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == BUS_CYCLE_LEN - 3'h1)
                        state_ff <= DPCM_IDLE;
                end
                default: state_ff <= DPCM_IDLE;
            endcase
        end
    end
    // Pins registered so every output comes straight from a flip-flop
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ale_out <= 1'b0;
            program_store_strobe_n_out <= 1'b1;
            ad_o_out <= 8'h00;
            ad_oe_n_out <= 8'hFF;
            upper_address_out <= 8'h00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            data_out <= 8'h00;
        end
        else
        begin
            busy_out <= (state_ff != DPCM_IDLE) || req_in;
            ale_out <= (state_ff == DPCM_ADDR) && (cnt_ff < ALE_END);
            upper_address_out <= addr_ff[15:8];
            ad_o_out <= addr_ff[7:0];
            ad_oe_n_out <= (state_ff == DPCM_ADDR) ? 8'h00 : 8'hFF;
            program_store_strobe_n_out <= !((state_ff == DPCM_DATA)
                && (cnt_ff >= STROBE_START) && (cnt_ff < STROBE_END));
            done_out <= (state_ff == DPCM_DATA) && (cnt_ff == STROBE_END);
            // Sample data while strobe still low, before release
            if ((state_ff == DPCM_DATA) && (cnt_ff == STROBE_END))
                data_out <= ad_sync_in;
        end
    end
endmodule

// ---- core/dpcm_pkg.sv ----
// Constants for the dual pointer and code memory map block
package dpcm_pkg;
    localparam logic [7:0] PBR_ADDR = 8'hA2;
    localparam int PBR_SEL_BIT = 0;
    localparam int PBR_ZERO_BIT = 2;
    localparam int PBR_FLAG_BIT = 3;
    localparam int PBR_BOOT_BIT = 5;
    localparam logic [7:0] PBR_RSVD_MASK = 8'hD2;
    localparam logic [7:0] PBR_RSVD_READ = 8'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] USER_FLASH_TOP = 16'h7FFF;
    localparam logic [15:0] BOOT_BASE = 16'hF400;
    localparam logic [15:0] BOOT_BASE_WIDE = 16'hF800;
    localparam int PAGE_BYTES = 128;
    localparam logic [3:0] OSC_PER_CYCLE_STD = 4'hC;
    localparam logic [3:0] OSC_PER_CYCLE_DOUBLE = 4'h6;
    localparam logic [2:0] BUS_CYCLE_LEN = 3'h6;
    localparam logic [2:0] ALE_END = 3'h1;
    localparam logic [2:0] STROBE_START = 3'h2;
    localparam logic [2:0] STROBE_END = 3'h5;
    typedef enum logic [2:0]
    {
        DPCM_IDLE = 3'b001,
        DPCM_ADDR = 3'b010,
        DPCM_DATA = 3'b100
    } dpcm_bus_state_t;
    typedef enum logic [1:0]
    {
        DPCM_SPACE_USER = 2'h0,
        DPCM_SPACE_BOOT = 2'h1,
        DPCM_SPACE_EXT = 2'h2
    } dpcm_space_t;
endpackage

// ---- core/dpcm_top.sv ----
// Dual data pointer, pointer/boot register and code memory map
`timescale 1ns/1ns
module dpcm_top
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Special function register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_inc_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // Data pointer operations
    input wire logic ptr_load_in,
    input wire logic [15:0] ptr_load_val_in,
    input wire logic ptr_inc_in,
    output logic [15:0] data_pointer_out,
    // Clock mode
    input wire logic double_speed_select_in,
    output logic [3:0] osc_per_machine_cycle_out,
    // Code fetch request
    input wire logic code_req_in,
    input wire logic code_is_fetch_in,
    input wire logic [15:0] code_addr_in,
    output logic code_busy_out,
    output logic code_done_out,
    output logic [7:0] code_ext_data_out,
    output logic [1:0] code_space_out,
    output logic [8:0] code_page_out,
    // Programming permission
    input wire logic serial_prog_in,
    output logic user_prog_allowed_out,
    output logic boot_prog_allowed_out,
    // External bus pins
    input wire logic [7:0] muxed_addr_data_low_in,
    output logic [7:0] muxed_addr_data_low_out,
    output logic [7:0] muxed_addr_data_low_oe_n_out,
    output logic [7:0] upper_address_out,
    output logic ale_out,
    output logic program_store_strobe_n_out
);
    import dpcm_pkg::*;

    logic pointer_select_ff;
    logic user_flag_bit_ff;
    logic boot_space_map_ff;
    logic [15:0] data_pointer_0_ff;
    logic [15:0] data_pointer_1_ff;
    logic [7:0] ad_meta_ff;
    logic [7:0] ad_sync_ff;
    logic ext_req;
    logic [15:0] ext_addr;
    logic reg_hit;
    logic [15:0] nxt_pointer;

    function automatic dpcm_space_t decode_space(input logic [15:0] a, input logic boot);
        if (boot && (a >= BOOT_BASE))
            decode_space = DPCM_SPACE_BOOT;
        else if (a <= USER_FLASH_TOP)
            decode_space = DPCM_SPACE_USER;
        else
            decode_space = DPCM_SPACE_EXT;
    endfunction

    assign reg_hit = (sfr_addr_in == PBR_ADDR);

    // Pointer/boot register; bit 2 has no storage so it always reads zero
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pointer_select_ff <= 1'b0;
            user_flag_bit_ff <= 1'b0;
            boot_space_map_ff <= 1'b0;
        end
        else if (reg_hit && sfr_inc_in)
        begin
            // Bit 2 stuck at zero absorbs the carry, so flag is untouched
            pointer_select_ff <= ~pointer_select_ff;
        end
        else if (reg_hit && sfr_wr_in)
        begin
            pointer_select_ff <= sfr_wdata_in[PBR_SEL_BIT];
            user_flag_bit_ff <= sfr_wdata_in[PBR_FLAG_BIT];
            boot_space_map_ff <= sfr_wdata_in[PBR_BOOT_BIT];
        end
    end

    // Reserved bits are don't-care on read; zero is returned
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            sfr_rdata_out <= 8'h00;
        else
        begin
            sfr_rdata_out <= PBR_RSVD_READ & PBR_RSVD_MASK;
            sfr_rdata_out[PBR_SEL_BIT] <= pointer_select_ff;
            sfr_rdata_out[PBR_ZERO_BIT] <= 1'b0;
            sfr_rdata_out[PBR_FLAG_BIT] <= user_flag_bit_ff;
            sfr_rdata_out[PBR_BOOT_BIT] <= boot_space_map_ff;
        end
    end

    always_comb
    begin
        nxt_pointer = pointer_select_ff ? data_pointer_1_ff : data_pointer_0_ff;
        if (ptr_load_in)
            nxt_pointer = ptr_load_val_in;
        else if (ptr_inc_in)
            nxt_pointer = nxt_pointer + 16'h0001;
    end

    // Only the selected pointer is written
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            data_pointer_0_ff <= PTR_RESET;
            data_pointer_1_ff <= PTR_RESET;
        end
        else if (!pointer_select_ff)
            data_pointer_0_ff <= nxt_pointer;
        else
            data_pointer_1_ff <= nxt_pointer;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            data_pointer_out <= PTR_RESET;
        else
            data_pointer_out <= nxt_pointer;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            osc_per_machine_cycle_out <= OSC_PER_CYCLE_STD;
        else if (double_speed_select_in)
            osc_per_machine_cycle_out <= OSC_PER_CYCLE_DOUBLE;
        else
            osc_per_machine_cycle_out <= OSC_PER_CYCLE_STD;
    end

    // Fetch at the last on-chip byte prefetches the next address externally
    always_comb
    begin
        ext_req = 1'b0;
        ext_addr = code_addr_in;
        if (code_req_in)
        begin
            if (decode_space(code_addr_in, boot_space_map_ff) == DPCM_SPACE_EXT)
                ext_req = 1'b1;
            else if (code_is_fetch_in && (code_addr_in == USER_FLASH_TOP))
            begin
                ext_req = 1'b1;
                ext_addr = code_addr_in + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            code_space_out <= DPCM_SPACE_USER;
            code_page_out <= 9'h000;
        end
        else if (code_req_in)
        begin
            code_space_out <= decode_space(code_addr_in, boot_space_map_ff);
            code_page_out <= 9'(code_addr_in / PAGE_BYTES);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            user_prog_allowed_out <= 1'b0;
            boot_prog_allowed_out <= 1'b0;
        end
        else
        begin
            user_prog_allowed_out <= 1'b1;
            boot_prog_allowed_out <= !serial_prog_in;
        end
    end

    // Pin input synchroniser
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ad_meta_ff <= 8'h00;
            ad_sync_ff <= 8'h00;
        end
        else
        begin
            ad_meta_ff <= muxed_addr_data_low_in;
            ad_sync_ff <= ad_meta_ff;
        end
    end

    dpcm_ext_bus u_bus
    (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .req_in(ext_req),
        .addr_in(ext_addr),
        .busy_out(code_busy_out),
        .done_out(code_done_out),
        .data_out(code_ext_data_out),
        .ad_sync_in(ad_sync_ff),
        .ad_o_out(muxed_addr_data_low_out),
        .ad_oe_n_out(muxed_addr_data_low_oe_n_out),
        .upper_address_out(upper_address_out),
        .ale_out(ale_out),
        .program_store_strobe_n_out(program_store_strobe_n_out)
    );
endmodule

// ---- verif/dpcm_ext_mem.sv ----
// External program memory model on the multiplexed bus
`timescale 1ns/1ns
module dpcm_ext_mem
(
    // Clock
    input wire logic clk_in,
    // Device pins
    input wire logic [7:0] ad_in,
    input wire logic [7:0] oe_n_in,
    input wire logic [7:0] up_in,
    input wire logic ale_in,
    input wire logic psn_in,
    // Resolved low port
    output logic [7:0] bus_out
);
    logic [7:0] lo_ff;
    logic [7:0] hi_ff;
    logic [7:0] last_ff = 8'h00;
    logic [7:0] drv;
    // Released port shows the inverse of its last level, never a held value
    assign drv = psn_in ? ~last_ff : (lo_ff ^ hi_ff ^ 8'h5A);
    assign bus_out = (~oe_n_in & ad_in) | (oe_n_in & drv);
    always_ff @(posedge clk_in)
    begin
        last_ff <= bus_out;
        if (ale_in)
        begin
            lo_ff <= bus_out;
            hi_ff <= up_in;
        end
    end
endmodule

// ---- verif/dpcm_properties.sv ----
// Port assertions for the dual pointer and code map block
`timescale 1ns/1ns
module dpcm_props
(
    // Clock, reset and register port
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_inc_in,
    input wire logic [7:0] sfr_rdata_out,
    // Code bus
    input wire logic [15:0] code_addr_in,
    input wire logic code_done_out,
    input wire logic [7:0] muxed_addr_data_low_out,
    input wire logic [7:0] muxed_addr_data_low_oe_n_out,
    input wire logic [7:0] upper_address_out,
    input wire logic ale_out,
    input wire logic program_store_strobe_n_out
);
    import dpcm_pkg::*;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_cycle;
        ##4 !code_done_out ##1 code_done_out;
    endsequence
    property p_ale_pulse;
        $rose(ale_out) |=> !ale_out;
    endproperty
    a_ale_pulse: assert property (p_ale_pulse) else $error("ale too long");
    property p_ale_drive;
        ale_out |-> muxed_addr_data_low_oe_n_out == 8'h00;
    endproperty
    a_ale_drive: assert property (p_ale_drive) else $error("low port idle at ale");
    // Fetch at the last on-chip byte prefetches the next address
    property p_addr;
        $rose(ale_out) |-> {upper_address_out, muxed_addr_data_low_out} ==
            (($past(code_addr_in) == USER_FLASH_TOP) ? 16'h8000 : $past(code_addr_in));
    endproperty
    a_addr: assert property (p_addr) else $error("bad bus address");
    property p_strobe;
        $fell(program_store_strobe_n_out) |=> !program_store_strobe_n_out
            ##[1:2] program_store_strobe_n_out;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe length");
    property p_release;
        !program_store_strobe_n_out |-> muxed_addr_data_low_oe_n_out == 8'hFF;
    endproperty
    a_release: assert property (p_release) else $error("port driven in data phase");
    property p_done;
        $rose(ale_out) |-> s_cycle;
    endproperty
    a_done: assert property (p_done) else $error("cycle length");
    property p_rsvd;
        (sfr_rdata_out & (PBR_RSVD_MASK | 8'h04)) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_inc;
        (sfr_inc_in && sfr_addr_in == PBR_ADDR) |->
            ##2 sfr_rdata_out[0] != $past(sfr_rdata_out[0]);
    endproperty
    a_inc: assert property (p_inc) else $error("select not toggled");
endmodule
bind dpcm_top dpcm_props u_props
(
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .sfr_addr_in(sfr_addr_in),
    .sfr_inc_in(sfr_inc_in),
    .sfr_rdata_out(sfr_rdata_out),
    .code_addr_in(code_addr_in),
    .code_done_out(code_done_out),
    .muxed_addr_data_low_out(muxed_addr_data_low_out),
    .muxed_addr_data_low_oe_n_out(muxed_addr_data_low_oe_n_out),
    .upper_address_out(upper_address_out),
    .ale_out(ale_out),
    .program_store_strobe_n_out(program_store_strobe_n_out)
);

// ---- verif/testbench.sv ----
// Self-checking bench for the dual pointer and code map block
`timescale 1ns/1ns
module testbench;
    import dpcm_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, inc = 1'h0, pld = 1'h0, pinc = 1'h0;
    logic ds = 1'h0, req = 1'h0, fetch = 1'h0, ser = 1'h0;
    logic busy, done, ale, psn, upa, bpa;
    logic [7:0] sa = 8'hA2, wd = 8'h00, rd, xd, ado, adoe, up, bus;
    logic [15:0] pv = 16'h0000, ca = 16'h0000, dp;
    logic [3:0] osc;
    logic [1:0] sp;
    logic [8:0] pg;
    int bad_count = 0, n_tests = 0, ales = 0;
    dpcm_top DUT
    (
        .core_clk_in(clk), .rst_n_in(rst_n),
        .sfr_addr_in(sa), .sfr_wr_in(wr), .sfr_inc_in(inc),
        .sfr_wdata_in(wd), .sfr_rdata_out(rd),
        .ptr_load_in(pld), .ptr_load_val_in(pv), .ptr_inc_in(pinc), .data_pointer_out(dp),
        .double_speed_select_in(ds), .osc_per_machine_cycle_out(osc),
        .code_req_in(req), .code_is_fetch_in(fetch), .code_addr_in(ca),
        .code_busy_out(busy), .code_done_out(done), .code_ext_data_out(xd),
        .code_space_out(sp), .code_page_out(pg),
        .serial_prog_in(ser), .user_prog_allowed_out(upa), .boot_prog_allowed_out(bpa),
        .muxed_addr_data_low_in(bus), .muxed_addr_data_low_out(ado),
        .muxed_addr_data_low_oe_n_out(adoe), .upper_address_out(up),
        .ale_out(ale), .program_store_strobe_n_out(psn)
    );
    dpcm_ext_mem u_mem
    (
        .clk_in(clk), .ad_in(ado), .oe_n_in(adoe), .up_in(up),
        .ale_in(ale), .psn_in(psn), .bus_out(bus)
    );
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(negedge clk)
    begin
        if (ale === 1'h1)
            ales <= ales + 1;
    end
    task wrap_up;
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task sfr(input logic [7:0] a, input logic w, input logic i, input logic [7:0] d);
        @(posedge clk);
        sa <= a;
        wr <= w;
        inc <= i;
        wd <= d;
        @(posedge clk);
        wr <= 1'h0;
        inc <= 1'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task pop(input logic l, input logic [15:0] v);
        @(posedge clk);
        pld <= l;
        pinc <= ~l;
        pv <= v;
        @(posedge clk);
        pld <= 1'h0;
        pinc <= 1'h0;
        @(negedge clk);
    endtask
    task t_reset;
        chk(rd & 8'h05, 8'h00);
        chk({psn, adoe}, 16'h01FF);
    endtask
    task t_reg;
        sfr(PBR_ADDR, 1'h1, 1'h0, 8'h2D);
        chk(rd, 8'h29);
        sfr(PBR_ADDR, 1'h0, 1'h1, 8'h00);
        chk(rd, 8'h28);
        sfr(8'hA3, 1'h1, 1'h0, 8'h01);
        chk(rd, 8'h28);
    endtask
    task t_ptr;
        pop(1'h1, 16'h1234);
        pop(1'h0, 16'h0000);
        chk(dp, 16'h1235);
        sfr(PBR_ADDR, 1'h0, 1'h1, 8'h00);
        chk(dp, PTR_RESET);
        pop(1'h1, 16'hABCD);
        sfr(PBR_ADDR, 1'h0, 1'h1, 8'h00);
        chk(dp, 16'h1235);
    endtask
    task t_code(input logic [15:0] a, input logic f, input logic [1:0] s, input logic x,
        input logic [15:0] e);
        int k;
        int n0;
        n0 = ales;
        @(posedge clk);
        req <= 1'h1;
        ca <= a;
        fetch <= f;
        @(posedge clk);
        req <= 1'h0;
        @(negedge clk);
        chk(sp, s);
        chk(pg, a[15:7]);
        chk(busy, x);
        k = 0;
        while (x && done !== 1'h1 && k < 20)
        begin
            @(negedge clk);
            k++;
        end
        chk(k, x ? BUS_CYCLE_LEN : 3'h0);
        if (x)
            chk(xd, e[7:0] ^ e[15:8] ^ 8'h5A);
        repeat (8) @(negedge clk);
        chk(ales - n0, x ? 1 : 0);
        chk(busy, 1'h0);
    endtask
    task t_mode;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            ds <= i[0];
            ser <= i[0];
            repeat (3) @(negedge clk);
            chk(osc, i ? 4'h6 : 4'hC);
            chk({upa, bpa}, {1'h1, ~i[0]});
        end
    endtask
    initial
    begin
        #300000;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        t_reset();
        t_reg();
        t_ptr();
        t_code(16'h0100, 1'h1, DPCM_SPACE_USER, 1'h0, 16'h0000);
        t_code(16'h7FFF, 1'h0, DPCM_SPACE_USER, 1'h0, 16'h0000);
        t_code(16'h7FFF, 1'h1, DPCM_SPACE_USER, 1'h1, 16'h8000);
        t_code(16'h9000, 1'h0, DPCM_SPACE_EXT, 1'h1, 16'h9000);
        t_code(BOOT_BASE, 1'h1, DPCM_SPACE_BOOT, 1'h0, 16'h0000);
        t_code(16'hF3FF, 1'h1, DPCM_SPACE_EXT, 1'h1, 16'hF3FF);
        sfr(PBR_ADDR, 1'h1, 1'h0, 8'h01);
        t_code(BOOT_BASE, 1'h1, DPCM_SPACE_EXT, 1'h1, BOOT_BASE);
        t_mode();
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        t_reset();
        wrap_up();
    end
endmodule
